/* File: verilog/e1_card_pkg.sv */
// Shared constants for the line-side E1 card status, alarm and mapping logic
package e1_card_pkg;
  localparam int unsigned CLK_KHZ      = 250000;
  localparam int unsigned SELFTEST_MS  = 3000;
  localparam int unsigned BLINK_MS     = 250;
  localparam int unsigned WINDOW_MS    = 1000;
  localparam int unsigned SELFTEST_CYC = SELFTEST_MS * CLK_KHZ;
  localparam int unsigned BLINK_CYC    = BLINK_MS * CLK_KHZ;
  localparam int unsigned WINDOW_CYC   = WINDOW_MS * CLK_KHZ;
  localparam logic [2:0]  BLINK_EDGES  = 3'h6;

  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_CMD    = 8'h04;
  localparam logic [7:0]  REG_STATUS = 8'h08;
  localparam logic [7:0]  REG_THRESH = 8'h0c;

  localparam int CTRL_SELF_CLEAR = 0;
  localparam int CTRL_TESTS      = 1;
  localparam int CTRL_ALM_OFF    = 2;
  localparam int CTRL_SLOT0_EN   = 3;
  localparam int CTRL_SLOT1_EN   = 4;
  localparam int CTRL_USER_LSB   = 8;
  localparam int CMD_CLEAR_ALARM = 0;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_e401;
  localparam logic [31:0] THRESH_RESET = 32'h0004_0010;

  localparam logic [4:0] NUM_CHAN    = 5'h1e;
  localparam logic [4:0] SLOT0_CHANS = 5'h10;
  localparam logic [4:0] TS_CAS      = 5'h10;

  localparam logic [1:0] SIG_ON_HOOK  = 2'h0;
  localparam logic [1:0] SIG_OFF_HOOK = 2'h1;
  localparam logic [1:0] SIG_RING     = 2'h2;

  localparam logic [1:0] SCHEME_NA   = 2'h0;
  localparam logic [1:0] SCHEME_AUS  = 2'h1;
  localparam logic [1:0] SCHEME_USER = 2'h2;
endpackage

/* File: verilog/e1_tick_timer.sv */
// Interval timer giving a one-cycle tick every PERIOD cycles while run is high; cleared while run is low
`timescale 1ns/1ns
`default_nettype none
module e1_tick_timer
  import e1_card_pkg::*;
#(
  parameter int unsigned PERIOD = 4
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic run,
  output logic      tick
);
  initial begin
    if (PERIOD < 1) $error("PERIOD must be at least one");
  end

  logic [31:0] count;
  logic [31:0] next_count;

  always_comb begin
    next_count = '0;
    if (run && count != PERIOD - 1) begin
      next_count = count + 32'h1;
    end
  end

  assign tick = run && (count == PERIOD - 1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/e1_line_card.sv */
// Status, alarm and channel mapping logic of the line-side E1 card
// How it works
// - Status lamp lit steadily during self-test
// - Pass: three blinks then steady; fail: endless blink
// - Lamp goes out once card enabled
// - Either slot enabled turns lamp off
// - Lamp relit only when both slots disabled
// - Red lamp on LOS, errors or slips
// - Send remote alarm while red condition lasts
// - Self-clearing: red lamp follows condition
// - Latched red lamp needs clear command
// - Yellow lamp shows received remote alarm
// - Maintenance lamp while tests or alarms off
// - Thirty channels, one timeslot each
// - Loop stream mapped to E1 and back
// - CRC-4 or FAS framing, AMI or HDB3
// - Loop signaling translated to A/B bits
// - Switch picks loop or ground start in the NA scheme only
// - Switch picks A/B signaling scheme
// - Sixteen channels first slot, fourteen second
// - Calls out from loop, status back on loop
// - Hook and ring messages become A/B bits
`timescale 1ns/1ns
`default_nettype none
module e1_line_card
  import e1_card_pkg::*;
#(
  parameter int unsigned SELFTEST_CYCLES = SELFTEST_CYC,
  parameter int unsigned BLINK_CYCLES    = BLINK_CYC,
  parameter int unsigned WINDOW_CYCLES   = WINDOW_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        selftest_fail,
  input  wire logic        sw_crc4,
  input  wire logic        sw_hdb3,
  input  wire logic        sw_ground_start,
  input  wire logic [1:0]  sw_scheme,
  input  wire logic        e1_los,
  input  wire logic        e1_rx_remote_alarm,
  input  wire logic        e1_bit_err,
  input  wire logic        e1_slip,
  output logic             e1_crc4_en,
  output logic             e1_hdb3_en,
  output logic             e1_tx_remote_alarm,
  input  wire logic        loop_tx_valid,
  input  wire logic [4:0]  loop_tx_chan,
  input  wire logic [7:0]  loop_tx_pcm,
  input  wire logic [1:0]  loop_tx_sig,
  output logic             e1_tx_valid,
  output logic      [4:0]  e1_tx_slot,
  output logic      [7:0]  e1_tx_byte,
  output logic      [1:0]  e1_tx_ab,
  input  wire logic        e1_rx_valid,
  input  wire logic [4:0]  e1_rx_slot,
  input  wire logic [7:0]  e1_rx_byte,
  input  wire logic [1:0]  e1_rx_ab,
  output logic             loop_rx_valid,
  output logic      [4:0]  loop_rx_chan,
  output logic      [7:0]  loop_rx_pcm,
  output logic      [1:0]  loop_rx_sig,
  output logic             loop_rx_card_slot,
  output logic             status_led,
  output logic             red_led,
  output logic             yellow_led,
  output logic             maint_led
);
  initial begin
    if (SELFTEST_CYCLES < 1 || BLINK_CYCLES < 1 || WINDOW_CYCLES < 1) begin
      $error("Interval counts must be at least one cycle");
    end
  end

  typedef enum logic [1:0] {ST_TEST, ST_BLINK, ST_READY, ST_FAIL} test_state_t;

  typedef struct packed {
    logic [7:0]       sync1;
    logic [7:0]       sync2;
    test_state_t      state;
    logic [31:0]      test_cnt;
    logic [2:0]       blink_cnt;
    logic             blink_on;
    logic [31:0]      ctrl;
    logic [31:0]      thresh;
    logic [15:0]      err_cnt;
    logic [15:0]      slip_cnt;
    logic             err_over;
    logic             slip_over;
    logic             red;
    logic             ack;
    logic [31:0]      rdata;
    logic [29:0][1:0] tx_ab;
    logic             tx_valid;
    logic [4:0]       tx_slot;
    logic [7:0]       tx_byte;
    logic             rx_valid;
    logic [4:0]       rx_chan;
    logic [7:0]       rx_pcm;
    logic [1:0]       rx_sig;
  } state_t;

  state_t q;
  state_t n;

  logic blink_tick;
  logic window_tick;
  logic los_s;
  logic rem_s;
  logic fail_s;
  logic gs_s;
  logic [1:0] scheme_s;
  logic red_cond;
  logic wr_hit;
  logic rd_hit;
  logic clear_cmd;

  // Pins are asynchronous to clk: only the second stage is ever read
  assign los_s    = q.sync2[0];
  assign rem_s    = q.sync2[1];
  assign fail_s   = q.sync2[2];
  assign gs_s     = q.sync2[3];
  assign scheme_s = q.sync2[5:4];

  e1_tick_timer #(.PERIOD(BLINK_CYCLES)) u_blink (
    .clk    (clk),
    .arst_n (arst_n),
    .run    (q.state == ST_BLINK || q.state == ST_FAIL),
    .tick   (blink_tick)
  );

  e1_tick_timer #(.PERIOD(WINDOW_CYCLES)) u_window (
    .clk    (clk),
    .arst_n (arst_n),
    .run    (1'b1),
    .tick   (window_tick)
  );

  // Translate a hook message into A/B bits for the selected scheme
  function automatic logic [1:0] ab_encode(input logic [1:0] scheme, input logic gs,
                                           input logic [1:0] sig, input logic [7:0] user);
    logic [1:0] ab;
    ab = 2'h1;
    case (scheme)
      SCHEME_AUS: ab = (sig == SIG_OFF_HOOK) ? 2'h3 : (sig == SIG_RING) ? 2'h0 : 2'h2;
      SCHEME_NA:  ab = (sig == SIG_OFF_HOOK) ? 2'h3 : (sig == SIG_RING) ? 2'h0
                     : (gs ? 2'h0 : 2'h1);
      default:    ab = user[2*sig +: 2];
    endcase
    return ab;
  endfunction

  assign red_cond  = los_s || q.err_over || q.slip_over;
  assign wr_hit    = wb_cyc_i && wb_stb_i && wb_we_i && !q.ack;
  assign rd_hit    = wb_cyc_i && wb_stb_i && !wb_we_i && !q.ack;
  assign clear_cmd = wr_hit && wb_adr_i == REG_CMD && wb_sel_i[0]
                     && wb_dat_i[CMD_CLEAR_ALARM];

  always_comb begin
    n = q;
    n.sync1 = {sw_hdb3, sw_crc4, sw_scheme, sw_ground_start, selftest_fail,
               e1_rx_remote_alarm, e1_los};
    n.sync2 = q.sync1;

    // Self-test and status lamp sequence
    case (q.state)
      ST_TEST: begin
        n.test_cnt = q.test_cnt + 32'h1;
        if (q.test_cnt == SELFTEST_CYCLES - 1) begin
          n.state    = fail_s ? ST_FAIL : ST_BLINK;
          n.blink_on = 1'b0;
          n.blink_cnt = '0;
        end
      end
      ST_BLINK: begin
        if (blink_tick) begin
          n.blink_on  = !q.blink_on;
          n.blink_cnt = q.blink_cnt + 3'h1;
          if (q.blink_cnt == BLINK_EDGES - 3'h1) begin
            n.state = ST_READY;
          end
        end
      end
      ST_FAIL: begin
        if (blink_tick) begin
          n.blink_on = !q.blink_on;
        end
      end
      ST_READY: n.blink_on = 1'b1;
      default:  n.state = ST_TEST;
    endcase

    // Error and slip counts over a fixed window
    n.err_cnt  = q.err_cnt + {15'h0, e1_bit_err};
    n.slip_cnt = q.slip_cnt + {15'h0, e1_slip};
    if (n.err_cnt > q.thresh[15:0]) begin
      n.err_over = 1'b1;
    end
    if (n.slip_cnt > q.thresh[31:16]) begin
      n.slip_over = 1'b1;
    end
    if (window_tick) begin
      n.err_over  = n.err_cnt > q.thresh[15:0];
      n.slip_over = n.slip_cnt > q.thresh[31:16];
      n.err_cnt   = '0;
      n.slip_cnt  = '0;
    end

    // Red lamp: follow the condition, or latch until cleared; a new alarm beats the clear
    if (q.ctrl[CTRL_SELF_CLEAR]) begin
      n.red = red_cond;
    end else if (red_cond) begin
      n.red = 1'b1;
    end else if (clear_cmd) begin
      n.red = 1'b0;
    end

    // Register bus: one wait state, unmapped reads return zero
    n.ack   = wb_cyc_i && wb_stb_i && !q.ack;
    n.rdata = '0;
    if (wr_hit) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          if (wb_adr_i == REG_CTRL) begin
            n.ctrl[8*b +: 8] = wb_dat_i[8*b +: 8];
          end
          if (wb_adr_i == REG_THRESH) begin
            n.thresh[8*b +: 8] = wb_dat_i[8*b +: 8];
          end
        end
      end
    end
    if (rd_hit) begin
      case (wb_adr_i)
        REG_CTRL:   n.rdata = q.ctrl;
        REG_THRESH: n.rdata = q.thresh;
        REG_STATUS: n.rdata = {22'h0, q.slip_over, q.err_over, q.state == ST_FAIL,
                               q.state == ST_READY, red_cond, maint_led, yellow_led,
                               q.red, status_led, los_s};
        default:    n.rdata = '0;
      endcase
    end

    // Loop to E1: channel to timeslot with A/B bits per channel
    n.tx_valid = 1'b0;
    if (loop_tx_valid && loop_tx_chan < NUM_CHAN) begin
      n.tx_valid = 1'b1;
      n.tx_slot  = (loop_tx_chan < 5'hf) ? loop_tx_chan + 5'h1 : loop_tx_chan + 5'h2;
      n.tx_byte  = loop_tx_pcm;
      n.tx_ab[loop_tx_chan] = ab_encode(scheme_s, gs_s, loop_tx_sig,
                                        q.ctrl[CTRL_USER_LSB +: 8]);
    end

    // E1 to loop: timeslot back to channel, A/B decoded to hook state
    n.rx_valid = 1'b0;
    if (e1_rx_valid && e1_rx_slot != 5'h0 && e1_rx_slot != TS_CAS) begin
      n.rx_valid = 1'b1;
      n.rx_chan  = (e1_rx_slot < TS_CAS) ? e1_rx_slot - 5'h1 : e1_rx_slot - 5'h2;
      n.rx_pcm   = e1_rx_byte;
      n.rx_sig   = SIG_ON_HOOK;
      if (e1_rx_ab == ab_encode(scheme_s, gs_s, SIG_OFF_HOOK, q.ctrl[CTRL_USER_LSB +: 8])) begin
        n.rx_sig = SIG_OFF_HOOK;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q           <= '0;
      q.state     <= ST_TEST;
      q.ctrl      <= CTRL_RESET;
      q.thresh    <= THRESH_RESET;
      q.tx_ab     <= '0;
    end else begin
      q <= n;
    end
  end

  assign wb_ack_o           = q.ack;
  assign wb_dat_o           = q.rdata;
  assign e1_crc4_en         = q.sync2[6];
  assign e1_hdb3_en         = q.sync2[7];
  // Condition, not the latched lamp: the carrier returns to service by itself
  assign e1_tx_remote_alarm = red_cond;
  assign e1_tx_valid        = q.tx_valid;
  assign e1_tx_slot         = q.tx_slot;
  assign e1_tx_byte         = q.tx_byte;
  assign loop_rx_valid      = q.rx_valid;
  assign loop_rx_chan       = q.rx_chan;
  assign loop_rx_pcm        = q.rx_pcm;
  assign loop_rx_sig        = q.rx_sig;
  assign loop_rx_card_slot  = q.rx_chan >= SLOT0_CHANS;
  assign red_led            = q.red;
  assign yellow_led         = rem_s;
  assign maint_led          = q.ctrl[CTRL_TESTS] | q.ctrl[CTRL_ALM_OFF];
  always_comb begin
    e1_tx_ab = q.tx_ab[0];
    if (q.tx_slot != 5'h0 && q.tx_slot != TS_CAS) begin
      e1_tx_ab = q.tx_ab[(q.tx_slot < TS_CAS) ? q.tx_slot - 5'h1 : q.tx_slot - 5'h2];
    end
  end
  always_comb begin
    status_led = 1'b1;
    case (q.state)
      ST_BLINK, ST_FAIL: status_led = q.blink_on;
      ST_READY: status_led = !(q.ctrl[CTRL_SLOT0_EN] || q.ctrl[CTRL_SLOT1_EN]);
      default:  status_led = 1'b1;
    endcase
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_s;
    wb_ack_o;
  endsequence

  test_lamp_a: assert property (q.state == ST_TEST |-> status_led)
    else $error("Status lamp dark during self-test");
  blink_count_a: assert property ($rose(q.state == ST_READY) |-> $past(q.state) == ST_BLINK
    && q.blink_cnt == BLINK_EDGES)
    else $error("Wrong number of blink edges before ready");
  slot_lamp_a: assert property (q.state == ST_READY && (q.ctrl[CTRL_SLOT0_EN]
    || q.ctrl[CTRL_SLOT1_EN]) |-> !status_led)
    else $error("Status lamp lit with a slot enabled");
  both_off_a: assert property (q.state == ST_READY && status_led |->
    !q.ctrl[CTRL_SLOT0_EN] && !q.ctrl[CTRL_SLOT1_EN])
    else $error("Status lamp lit before both slots disabled");
  remote_tx_a: assert property (red_cond |-> e1_tx_remote_alarm)
    else $error("Remote alarm not sent during red condition");
  self_clear_a: assert property (q.ctrl[CTRL_SELF_CLEAR] && !red_cond
    ##1 q.ctrl[CTRL_SELF_CLEAR] |-> !red_led)
    else $error("Red lamp not self-cleared");
  red_latch_a: assert property (!q.ctrl[CTRL_SELF_CLEAR] && red_led && !clear_cmd
    ##1 !q.ctrl[CTRL_SELF_CLEAR] |-> red_led)
    else $error("Latched red lamp dropped without clear");
  yellow_lamp_a: assert property (e1_rx_remote_alarm [*3] |-> yellow_led)
    else $error("Yellow lamp not following remote alarm");
  maint_lamp_a: assert property (q.ctrl[CTRL_TESTS] |-> maint_led)
    else $error("Maintenance lamp dark while tests run");
  map_tx_a: assert property (loop_tx_valid && loop_tx_chan == 5'h0f |=>
    e1_tx_valid && e1_tx_slot == 5'h11)
    else $error("Channel to timeslot mapping wrong");
  bus_ack_a: assert property (bus_req_s |=> ack_s ##1 !wb_ack_o)
    else $error("Bus answer not one cycle later");
endmodule
`default_nettype wire

/* File: verif/e1_far_end.sv */
// Behavioural model of the E1 terminal equipment facing the card
`timescale 1ns/1ns
`default_nettype none
module e1_far_end (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       rx_send,
  input  wire logic [4:0] rx_slot,
  input  wire logic [7:0] rx_byte,
  input  wire logic [1:0] rx_ab,
  input  wire logic       rx_fault,
  output logic            e1_rx_valid,
  output logic      [4:0] e1_rx_slot,
  output logic      [7:0] e1_rx_byte,
  output logic      [1:0] e1_rx_ab,
  output logic            e1_rx_remote_alarm
);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      e1_rx_valid <= 1'b0;
      e1_rx_slot  <= 5'h00;
      e1_rx_byte  <= 8'h00;
      e1_rx_ab    <= 2'h0;
    end else if (rx_send) begin
      e1_rx_valid <= 1'b1;
      e1_rx_slot  <= rx_slot;
      e1_rx_byte  <= rx_byte;
      e1_rx_ab    <= rx_ab;
    end else begin
      // Idle lines toggle, so stale data never looks fresh
      e1_rx_valid <= 1'b0;
      e1_rx_slot  <= ~e1_rx_slot;
      e1_rx_byte  <= ~e1_rx_byte;
      e1_rx_ab    <= ~e1_rx_ab;
    end
  end
  // Fault on its own receive side answered by remote alarm
  assign e1_rx_remote_alarm = rx_fault;
endmodule
`default_nettype wire

/* File: verif/e1_line_card_tb_top.sv */
// Self-checking bench of the line card status, alarm and mapping logic
`timescale 1ns/1ns
`default_nettype none
module e1_line_card_tb_top;
  import e1_card_pkg::*;
  typedef struct packed {logic [4:0] ch; logic [4:0] sl; logic ok;} row_t;
  logic clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, loop_tx_pcm, e1_tx_byte, e1_rx_byte, loop_rx_pcm, rx_byte;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic selftest_fail, sw_crc4, sw_hdb3, sw_ground_start, e1_los, e1_bit_err, e1_slip;
  logic e1_rx_remote_alarm, e1_crc4_en, e1_hdb3_en, e1_tx_remote_alarm;
  logic loop_tx_valid, e1_tx_valid, e1_rx_valid, loop_rx_valid, loop_rx_card_slot;
  logic [4:0] loop_tx_chan, e1_tx_slot, e1_rx_slot, loop_rx_chan, rx_slot;
  logic [1:0] sw_scheme, loop_tx_sig, e1_tx_ab, e1_rx_ab, loop_rx_sig, rx_ab;
  logic status_led, red_led, yellow_led, maint_led, rx_send, rx_fault;
  logic tv, rv, rcs;
  logic [4:0] ts, rch;
  logic [7:0] tbyte, rpcm;
  logic [1:0] tab, rsig;
  int fails, checked;
  row_t rows [7] = '{'{5'h00, 5'h01, 1'b1}, '{5'h0e, 5'h0f, 1'b1}, '{5'h0f, 5'h11, 1'b1},
    '{5'h10, 5'h12, 1'b1}, '{5'h1d, 5'h1f, 1'b1}, '{5'h1e, 5'h00, 1'b0}, '{5'h1f, 5'h10, 1'b0}};
  int slot_seq [6] = '{1, 3, 2, 0, 2, 0};

  // Short intervals keep the boot sequence to a few dozen cycles
  e1_line_card #(.SELFTEST_CYCLES(20), .BLINK_CYCLES(4), .WINDOW_CYCLES(50)) uut (.*);
  e1_far_end far (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic test_done();
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bail();
    fails++;
    test_done();
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) bail();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
    repeat (3) @(posedge clk);
  endtask

  task automatic wait_red(input logic want);
    int n;
    n = 0;
    while (red_led !== want && n < 150) begin
      @(posedge clk);
      n++;
    end
    if (red_led !== want) bail();
  endtask

  // Loop side and far end send together; results captured at settle edges
  task automatic xfer(input logic [4:0] ch, input logic [1:0] sg, input logic [4:0] sl,
                      input logic [1:0] ab);
    @(posedge clk);
    loop_tx_valid <= 1'b1;
    loop_tx_chan  <= ch;
    loop_tx_pcm   <= {3'h5, ch};
    loop_tx_sig   <= sg;
    rx_send       <= 1'b1;
    rx_slot       <= sl;
    rx_byte       <= {3'h2, sl};
    rx_ab         <= ab;
    @(posedge clk);
    loop_tx_valid <= 1'b0;
    rx_send       <= 1'b0;
    @(posedge clk);
    {tv, ts, tbyte, tab} = {e1_tx_valid, e1_tx_slot, e1_tx_byte, e1_tx_ab};
    @(posedge clk);
    {rv, rch, rpcm, rsig, rcs} = {loop_rx_valid, loop_rx_chan, loop_rx_pcm, loop_rx_sig,
                                  loop_rx_card_slot};
  endtask

  task automatic boot(input logic fl, output int falls);
    logic prev;
    falls = 0;
    arst_n <= 1'b0;
    selftest_fail <= fl;
    repeat (16) @(posedge clk);
    chk({status_led, red_led, yellow_led, maint_led}, 4'h8);
    arst_n <= 1'b1;
    repeat (16) begin
      @(posedge clk);
      chk(status_led, 1'b1);
    end
    prev = 1'b1;
    repeat (120) begin
      @(posedge clk);
      if (prev && !status_led) falls++;
      prev = status_led;
    end
  endtask

  initial begin
    int falls;
    logic [31:0] q;
    logic [1:0] off;
    {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    {selftest_fail, sw_crc4, sw_hdb3, sw_ground_start, sw_scheme} = '0;
    {e1_los, e1_bit_err, e1_slip, rx_fault, rx_send, rx_slot, rx_byte, rx_ab} = '0;
    {loop_tx_valid, loop_tx_chan, loop_tx_pcm, loop_tx_sig} = '0;
    boot(1'b0, falls);
    chk(falls, 3);
    chk(status_led, 1'b1);
    wb(1'b0, REG_CTRL, 32'h0, q);
    chk(q, CTRL_RESET);
    wb(1'b0, REG_THRESH, 32'h0, q);
    chk(q, THRESH_RESET);
    wb(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    foreach (slot_seq[i]) begin
      wr(REG_CTRL, CTRL_RESET | (slot_seq[i] << CTRL_SLOT0_EN));
      chk(status_led, slot_seq[i] == 0);
    end
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, CTRL_RESET | (i << CTRL_TESTS));
      chk(maint_led, i != 0);
    end
    e1_los <= 1'b1;
    wait_red(1'b1);
    chk(e1_tx_remote_alarm, 1'b1);
    e1_los <= 1'b0;
    wait_red(1'b0);
    chk(e1_tx_remote_alarm, 1'b0);
    // Six pulses: a window edge inside the burst still leaves three on one side
    wr(REG_THRESH, 32'h0002_0002);
    repeat (6) begin
      @(posedge clk);
      e1_slip    <= 1'b1;
      e1_bit_err <= 1'b1;
      @(posedge clk);
      e1_slip    <= 1'b0;
      e1_bit_err <= 1'b0;
    end
    wait_red(1'b1);
    chk(red_led, 1'b1);
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk(q[9:8], 2'h3);
    wait_red(1'b0);
    chk(red_led, 1'b0);
    wr(REG_CTRL, CTRL_RESET & ~32'h1);
    e1_los <= 1'b1;
    repeat (8) @(posedge clk);
    e1_los <= 1'b0;
    repeat (8) @(posedge clk);
    chk(red_led, 1'b1);
    chk(e1_tx_remote_alarm, 1'b0);
    wr(REG_CMD, 32'h1);
    chk(red_led, 1'b0);
    rx_fault <= 1'b1;
    repeat (6) @(posedge clk);
    chk(yellow_led, 1'b1);
    rx_fault <= 1'b0;
    repeat (6) @(posedge clk);
    chk(yellow_led, 1'b0);
    sw_crc4 <= 1'b1;
    sw_hdb3 <= 1'b1;
    repeat (6) @(posedge clk);
    chk({e1_crc4_en, e1_hdb3_en}, 2'h3);
    foreach (rows[i]) begin
      xfer(rows[i].ch, SIG_ON_HOOK, rows[i].sl, 2'h0);
      chk({tv, rv}, {2{rows[i].ok}});
      if (rows[i].ok) begin
        chk({ts, tbyte}, {rows[i].sl, 3'h5, rows[i].ch});
        chk({rch, rpcm, rcs}, {rows[i].ch, 3'h2, rows[i].sl, rows[i].ch >= SLOT0_CHANS});
      end
    end
    for (int s = 0; s < 3; s++) begin
      sw_scheme <= s[1:0];
      repeat (6) @(posedge clk);
      xfer(5'h03, SIG_OFF_HOOK, 5'h01, 2'h0);
      off = tab;
      if (s == 2) chk(off, CTRL_RESET[CTRL_USER_LSB + 2 +: 2]);
      xfer(5'h03, SIG_ON_HOOK, 5'h01, off);
      chk(off != tab, 1'b1);
      chk(rsig, SIG_OFF_HOOK);
      xfer(5'h03, SIG_ON_HOOK, 5'h01, tab);
      chk(rsig, SIG_ON_HOOK);
    end
    sw_scheme <= SCHEME_NA;
    repeat (6) @(posedge clk);
    xfer(5'h03, SIG_ON_HOOK, 5'h01, 2'h0);
    off = tab;
    sw_ground_start <= 1'b1;
    repeat (6) @(posedge clk);
    xfer(5'h03, SIG_ON_HOOK, 5'h01, 2'h0);
    chk(off != tab, 1'b1);
    boot(1'b1, falls);
    chk(falls > 3, 1'b1);
    test_done();
  end
endmodule
`default_nettype wire
